// [adc_monitor_gain_offset_regs.sv]
// Monitor select, gain/rate and offset coefficient registers of a
// delta-sigma converter, with the front-end settings they produce and
// the offset/full-scale correction of each raw result.
// Assumes a serial command decoder on clk_i presents byte accesses.
//
// Notes on behaviour
// - Monitor bit 7 reads 0 for internal, 1 for external clock.
// - A monitor code other than normal overrides the bias enables.
// - Code 000 is normal input (reset); 001 ties both inputs to mid-supply.
// - Code 010 routes the reference as full scale; 011 the temperature diode.
// - Codes 010 and 011 force gain 1; 000 and 001 use the gain field.
// - Leaving a forced-gain code restores the untouched gain field.
// - Bit 7 of the gain/rate register reads zero; the host writes zero.
// - Gain field bits 6:4 select gain two to the code, 1 up to 128.
// - Rate field bits 3:0 select 5 SPS doubling up to 640 SPS at 0111.
// - Rate code 1000 gives 1000 SPS, codes 1001 to 1111 give 2000 SPS.
// - The 24-bit offset spans three bytes, low byte first, reset zero.
// - The offset is signed and aligned left to the 24-bit result.
// - The offset is subtracted from each raw result before scaling.
// - A finished offset calibration writes its result into the offset.
// - The corrected result is scaled by the full-scale coefficient/400000h.
`include "adc_regs_defs.svh"

module adc_monitor_gain_offset_regs (
    input  wire logic                       clk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic [3:0]                 reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic [7:0]                 reg_wdata_i,
    input  wire logic                       reg_rd_i,
    output logic      [7:0]                 reg_rdata_o,
    output logic                            reg_rvalid_o,
    input  wire logic                       ext_clk_active_i,
    input  wire logic [1:0]                 bias_voltage_enable_i,
    input  wire logic                       offset_cal_done_i,
    input  wire logic [23:0]                offset_cal_value_i,
    input  wire logic [23:0]                fullscale_coeff_i,
    input  wire adc_regs_pkg::sample_s      raw_sample_i,
    output adc_regs_pkg::frontend_cfg_s     frontend_cfg_o,
    output adc_regs_pkg::sample_s           result_o
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic [7:0] gain_factor(input logic [2:0] code);
        gain_factor = 8'h01 << code;
    endfunction

    function automatic logic [11:0] rate_sps(input logic [3:0] code);
        if (code < `RATE_1K_CODE) begin
            rate_sps = `RATE_BASE_SPS << code[2:0];
        end else if (code == `RATE_1K_CODE) begin
            rate_sps = `RATE_1K_SPS;
        end else begin
            rate_sps = `RATE_2K_SPS;
        end
    endfunction

    function automatic logic forces_unity(input logic [2:0] code);
        forces_unity = (code == 3'h2) || (code == 3'h3);
    endfunction

    // ****************************************************************
    // Clock source flag synchroniser
    // ****************************************************************
    logic clk_flag_meta_r;
    logic clk_flag_r;
    logic clk_flag_meta_nxt;
    logic clk_flag_nxt;

    always_comb begin
        clk_flag_meta_nxt = ext_clk_active_i;
        clk_flag_nxt      = clk_flag_meta_r;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_flag_meta_r <= 1'b0;
            clk_flag_r      <= 1'b0;
        end else begin
            clk_flag_meta_r <= clk_flag_meta_nxt;
            clk_flag_r      <= clk_flag_nxt;
        end
    end

    // ****************************************************************
    // Writable state
    // ****************************************************************
    logic [2:0]  mon_sel_r;
    logic [2:0]  mon_sel_nxt;
    logic [2:0]  gain_code_r;
    logic [2:0]  gain_code_nxt;
    logic [3:0]  rate_code_r;
    logic [3:0]  rate_code_nxt;
    logic [23:0] offset_coeff_r;
    logic [23:0] offset_coeff_nxt;
    logic [7:0]  wr_ofs_byte;

    always_comb begin
        mon_sel_nxt      = mon_sel_r;
        gain_code_nxt    = gain_code_r;
        rate_code_nxt    = rate_code_r;
        offset_coeff_nxt = offset_coeff_r;
        wr_ofs_byte      = reg_wdata_i;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `MON_SEL_ADDR: begin
                    // Clock flag and reserved bits are not stored
                    mon_sel_nxt = reg_wdata_i[`MON_SEL_MSB:`MON_SEL_LSB];
                end
                `GAIN_RATE_ADDR: begin
                    // Bit 7 is dropped; it always reads zero
                    gain_code_nxt = reg_wdata_i[`GAIN_MSB:`GAIN_LSB];
                    rate_code_nxt = reg_wdata_i[`RATE_MSB:`RATE_LSB];
                end
                `OFS_LOW_ADDR: begin
                    offset_coeff_nxt[7:0] = wr_ofs_byte;
                end
                `OFS_MID_ADDR: begin
                    offset_coeff_nxt[15:8] = wr_ofs_byte;
                end
                `OFS_HIGH_ADDR: begin
                    offset_coeff_nxt[23:16] = wr_ofs_byte;
                end
                default: begin
                end
            endcase
        end
        // Calibration result wins over a host write in the same cycle
        if (offset_cal_done_i) begin
            offset_coeff_nxt = offset_cal_value_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mon_sel_r      <= `MON_SEL_RST;
            gain_code_r    <= `GAIN_RST;
            rate_code_r    <= `RATE_RST;
            offset_coeff_r <= `OFS_RST;
        end else begin
            mon_sel_r      <= mon_sel_nxt;
            gain_code_r    <= gain_code_nxt;
            rate_code_r    <= rate_code_nxt;
            offset_coeff_r <= offset_coeff_nxt;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;

    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = reg_rd_i;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `MON_SEL_ADDR: begin
                    rdata_nxt = {clk_flag_r, 4'h0, mon_sel_r};
                end
                `GAIN_RATE_ADDR: begin
                    rdata_nxt = {1'b0, gain_code_r, rate_code_r};
                end
                `OFS_LOW_ADDR: begin
                    rdata_nxt = offset_coeff_r[7:0];
                end
                `OFS_MID_ADDR: begin
                    rdata_nxt = offset_coeff_r[15:8];
                end
                `OFS_HIGH_ADDR: begin
                    rdata_nxt = offset_coeff_r[23:16];
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // ****************************************************************
    // Effective front-end settings
    // ****************************************************************
    adc_regs_pkg::frontend_cfg_s cfg_r;
    adc_regs_pkg::frontend_cfg_s cfg_nxt;
    logic [2:0]                  eff_gain;

    always_comb begin
        // The stored gain field is never overwritten by forcing
        eff_gain = forces_unity(mon_sel_r) ? `UNITY_GAIN_CODE
                                           : gain_code_r;
        cfg_nxt.gain_code   = eff_gain;
        cfg_nxt.gain_factor = gain_factor(eff_gain);
        cfg_nxt.rate_code   = rate_code_r;
        cfg_nxt.rate_sps    = rate_sps(rate_code_r);
        cfg_nxt.bias_enable = (mon_sel_r == `MON_SEL_RST)
                            ? bias_voltage_enable_i : 2'h0;
        unique case (mon_sel_r)
            3'h1:    cfg_nxt.input_route = adc_regs_pkg::MON_OFFSET;
            3'h2:    cfg_nxt.input_route = adc_regs_pkg::MON_FULLSCALE;
            3'h3:    cfg_nxt.input_route = adc_regs_pkg::MON_TEMP;
            default: cfg_nxt.input_route = adc_regs_pkg::MON_NORMAL;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_r <= '{input_route: adc_regs_pkg::MON_NORMAL,
                       bias_enable: 2'h0,
                       gain_code:   `GAIN_RST,
                       gain_factor: 8'h01,
                       rate_code:   `RATE_RST,
                       rate_sps:    `RATE_BASE_SPS};
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    assign frontend_cfg_o = cfg_r;

    // ****************************************************************
    // Result correction
    // ****************************************************************
    adc_offset_scale u_correct (
        .clk_i             (clk_i),
        .sys_rst_i         (sys_rst_i),
        .raw_i             (raw_sample_i),
        .offset_coeff_i    (offset_coeff_r),
        .fullscale_coeff_i (fullscale_coeff_i),
        .result_o          (result_o)
    );

endmodule // adc_monitor_gain_offset_regs

// [adc_regs_defs.svh]
// Offsets, field positions, reset values and scaling constants of the
// converter's monitor, gain/rate and offset coefficient registers.
// Assumes nothing; definitions only.
`ifndef ADC_REGS_DEFS_SVH
`define ADC_REGS_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define MON_SEL_ADDR      4'h2
`define GAIN_RATE_ADDR    4'h3
`define OFS_LOW_ADDR      4'h4
`define OFS_MID_ADDR      4'h5
`define OFS_HIGH_ADDR     4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define CLK_FLAG_BIT      7
`define MON_SEL_MSB       2
`define MON_SEL_LSB       0
`define GR_RSVD_BIT       7
`define GAIN_MSB          6
`define GAIN_LSB          4
`define RATE_MSB          3
`define RATE_LSB          0

// ****************************************************************
// Reset values
// ****************************************************************
`define MON_SEL_RST       3'h0
`define GAIN_RST          3'h0
`define RATE_RST          4'h0
`define OFS_RST           24'h000000

// ****************************************************************
// Rate table and coefficient alignment
// ****************************************************************
`define RATE_BASE_SPS     12'h005
`define RATE_1K_CODE      4'h8
`define RATE_1K_SPS       12'h3e8
`define RATE_2K_SPS       12'h7d0
`define UNITY_GAIN_CODE   3'h0
`define FSC_DIV_SHIFT     22
`define OFS_ALIGN_SHIFT   0

`endif

// [adc_regs_pkg.sv]
// Types shared by the register bank and its correction datapath.
// Assumes adc_regs_defs.svh is not needed here.
package adc_regs_pkg;

    typedef enum logic [2:0] {
        MON_NORMAL,
        MON_OFFSET,
        MON_FULLSCALE,
        MON_TEMP
    } monitor_e;

    typedef struct packed {
        monitor_e    input_route;
        logic [1:0]  bias_enable;
        logic [2:0]  gain_code;
        logic [7:0]  gain_factor;
        logic [3:0]  rate_code;
        logic [11:0] rate_sps;
    } frontend_cfg_s;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } sample_s;

endpackage

// [adc_offset_scale.sv]
// Offset subtraction and full-scale scaling of conversion results.
// Assumes one clock; coefficients are stable; the caller registers the offset, not the full-scale value.
`include "adc_regs_defs.svh"

module adc_offset_scale (
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire adc_regs_pkg::sample_s     raw_i,
    input  wire logic [23:0]               offset_coeff_i,
    input  wire logic [23:0]               fullscale_coeff_i,
    output adc_regs_pkg::sample_s          result_o
);

    // ****************************************************************
    // Stage 1: subtract aligned offset
    // ****************************************************************
    logic signed [24:0] diff_r;
    logic signed [24:0] diff_nxt;
    logic               v1_r;
    logic               v1_nxt;
    logic signed [23:0] ofs_aligned;

    always_comb begin
        ofs_aligned = $signed(offset_coeff_i) <<< `OFS_ALIGN_SHIFT;
        v1_nxt      = raw_i.valid;
        diff_nxt    = diff_r;
        if (raw_i.valid) begin
            diff_nxt = $signed({raw_i.data[23], raw_i.data})
                     - $signed({ofs_aligned[23], ofs_aligned});
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            diff_r <= 25'h0000000;
            v1_r   <= 1'b0;
        end else begin
            diff_r <= diff_nxt;
            v1_r   <= v1_nxt;
        end
    end

    // ****************************************************************
    // Stage 2: multiply by coefficient / 400000h, saturate
    // ****************************************************************
    logic signed [49:0] prod;
    logic signed [27:0] scaled;
    adc_regs_pkg::sample_s res_r;
    adc_regs_pkg::sample_s res_nxt;

    always_comb begin
        prod          = diff_r * $signed({1'b0, fullscale_coeff_i});
        scaled        = 28'(prod >>> `FSC_DIV_SHIFT);
        res_nxt.valid = v1_r;
        res_nxt.data  = res_r.data;
        if (v1_r) begin
            if (scaled > 28'sh07fffff) begin
                res_nxt.data = 24'h7fffff;
            end else if (scaled < -28'sh0800000) begin
                res_nxt.data = 24'h800000;
            end else begin
                res_nxt.data = scaled[23:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    assign result_o = res_r;

endmodule // adc_offset_scale

// [host_model.sv]
// Host controller model: byte reads and writes on the register port.
// Assumes the bench calls its tasks; strobes change at falling edges.
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic      [3:0] addr_o,
    output logic            wr_o,
    output logic      [7:0] wdata_o,
    output logic            rd_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        addr_o = 4'h0;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = (a == 4'h3) ? {1'b0, d[6:0]} : d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~wdata_o;
    endtask
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        d = rvalid_i ? rdata_i : 8'hxx;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule // host_model

// [adc_regs_monitor.sv]
// Concurrent checks on the register bank's ports.
// Assumes it is bound into adc_monitor_gain_offset_regs.
module adc_regs_monitor (
    input wire logic                        clk_i,
    input wire logic                        sys_rst_i,
    input wire logic [3:0]                  reg_addr_i,
    input wire logic                        reg_wr_i,
    input wire logic [7:0]                  reg_wdata_i,
    input wire logic                        reg_rd_i,
    input wire logic [7:0]                  reg_rdata_o,
    input wire logic                        reg_rvalid_o,
    input wire adc_regs_pkg::frontend_cfg_s frontend_cfg_o,
    input wire adc_regs_pkg::sample_s       raw_sample_i,
    input wire adc_regs_pkg::sample_s       result_o
);
    timeunit 1ns;
    timeprecision 100ps;
    adc_regs_pkg::frontend_cfg_s c;
    logic [11:0]                 sps_exp;
    assign c = frontend_cfg_o;
    assign sps_exp = c.rate_code < 4'h8 ? 12'h005 << c.rate_code :
                     (c.rate_code == 4'h8 ? 12'h3e8 : 12'h7d0);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_rvalid_after_rd: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read data valid missing");
    chk_rvalid_has_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("read data valid without read");
    chk_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 4'h2 ||
        reg_addr_i > 4'h6) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_mon_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 4'h2
        |=> reg_rdata_o[6:3] == 4'h0) else $error("monitor reserved set");
    chk_gr_msb_zero: assert property (reg_rd_i && reg_addr_i == 4'h3
        |=> !reg_rdata_o[7]) else $error("gain/rate bit 7 set");
    chk_rate_follows: assert property (reg_wr_i && reg_addr_i == 4'h3
        |-> ##2 c.rate_code == $past(reg_wdata_i[3:0], 2))
        else $error("rate code not applied");
    chk_gain_forced: assert property (c.input_route inside
        {adc_regs_pkg::MON_FULLSCALE, adc_regs_pkg::MON_TEMP}
        |-> c.gain_code == 3'h0) else $error("gain not forced");
    chk_bias_masked: assert property (c.input_route !=
        adc_regs_pkg::MON_NORMAL |-> c.bias_enable == 2'h0)
        else $error("bias not masked");
    chk_gain_factor: assert property (
        c.gain_factor == 8'h01 << c.gain_code)
        else $error("gain factor wrong");
    chk_sps_table: assert property (c.rate_sps == sps_exp)
        else $error("sample rate wrong");
    chk_result_latency: assert property (raw_sample_i.valid
        |-> ##2 result_o.valid) else $error("result late");
    chk_result_cause: assert property (result_o.valid
        |-> $past(raw_sample_i.valid, 2)) else $error("result without sample");
    cover property (reg_rvalid_o);
    cover property (result_o.valid);
    cover property (c.input_route == adc_regs_pkg::MON_TEMP);
endmodule // adc_regs_monitor

bind adc_monitor_gain_offset_regs adc_regs_monitor u_mon (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .frontend_cfg_o(frontend_cfg_o), .raw_sample_i(raw_sample_i),
    .result_o(result_o));

// [adc_monitor_gain_offset_regs_test.sv]
// Self-checking bench for the converter register bank.
// Assumes host_model drives the register port; checker is bound.
module adc_monitor_gain_offset_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic                        clk_i = 1'b0;
    logic                        sys_rst_i, ext_clk, cal_done, wr, rd, rvalid;
    logic [1:0]                  bias;
    logic [3:0]                  addr;
    logic [7:0]                  wdata, rdata, rb;
    logic [23:0]                 cal_val, fullscale_coeff, ofs;
    adc_regs_pkg::sample_s       raw, result;
    adc_regs_pkg::frontend_cfg_s cfg;
    logic [23:0]                 exp_q[$];
    int                          fail_count, num_checks, cycles;
    int                          rst_addr[7] = '{2, 3, 4, 5, 6, 0, 15};

    always #10 clk_i = ~clk_i;
    host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
        .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
    adc_monitor_gain_offset_regs DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .ext_clk_active_i(ext_clk), .bias_voltage_enable_i(bias),
        .offset_cal_done_i(cal_done), .offset_cal_value_i(cal_val),
        .fullscale_coeff_i(fullscale_coeff), .raw_sample_i(raw),
        .frontend_cfg_o(cfg), .result_o(result));

    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Model of the front-end settings packed msb first
    function automatic logic [31:0] cfg_exp(int m, int g, int r,
                                            logic [1:0] b);
        int eg;
        int sps;
        eg = (m == 2 || m == 3) ? 0 : g;
        sps = r < 8 ? 5 << r : (r == 8 ? 1000 : 2000);
        // Codes 4 to 7 route as normal but still mask the bias enables
        return {(m < 4) ? m[2:0] : 3'h0, (m == 0) ? b : 2'b00,
                eg[2:0], 8'(1 << eg), r[3:0], sps[11:0]};
    endfunction
    function automatic logic [23:0] res_exp(logic [23:0] d, o, f);
        longint p;
        p = (longint'($signed(d)) - longint'($signed(o)))
            * longint'(f) >>> 22;
        if (p > 64'sd8388607)
            p = 64'sd8388607;
        if (p < -64'sd8388608)
            p = -64'sd8388608;
        return p[23:0];
    endfunction
    task automatic check_ofs;
        for (int k = 0; k < 3; k++) begin
            host.read_reg(4'(4 + k), rb);
            check("offset byte", rb, ofs[8*k +: 8]);
        end
    endtask
    task automatic run_samples(input int n);
        repeat (n) begin
            @(negedge clk_i);
            raw.valid = 1'b1;
            raw.data = 24'($urandom);
            exp_q.push_back(res_exp(raw.data, ofs, fullscale_coeff));
        end
        @(negedge clk_i);
        raw.valid = 1'b0;
        repeat (3) @(negedge clk_i);
        check("results drained", exp_q.size(), 0);
    endtask

    always @(negedge clk_i) begin
        if (!sys_rst_i && result.valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("spurious result", 1, 0);
            else
                check("result data", result.data, exp_q.pop_front());
        end
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(73209));
        sys_rst_i = 1'b1;
        ext_clk = 1'b0;
        cal_done = 1'b0;
        cal_val = 24'h000000;
        fullscale_coeff = 24'h400000;
        bias = 2'h0;
        raw = '0;
        ofs = 24'h000000;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        check("cfg reset", cfg, cfg_exp(0, 0, 0, 2'h0));
        foreach (rst_addr[j]) begin
            host.read_reg(4'(rst_addr[j]), rb);
            check("reset read", rb, 0);
        end
        ext_clk = 1'b1;
        bias = 2'h3;
        host.write_reg(4'h2, 8'hff);
        host.read_reg(4'h2, rb);
        check("monitor ext clock", rb, 8'h87);
        check("spare code cfg", cfg, cfg_exp(7, 0, 0, 2'h3));
        ext_clk = 1'b0;
        repeat (3) @(negedge clk_i);
        host.read_reg(4'h2, rb);
        check("monitor int clock", rb, 8'h07);
        for (int i = 0; i < 16; i++) begin
            bias = 2'($urandom);
            host.write_reg(4'h3, {1'b0, i[2:0], i[3:0]});
            host.read_reg(4'h3, rb);
            check("gain rate read", rb, {1'b0, i[2:0], i[3:0]});
            for (int m = 2; m < 6; m++) begin
                host.write_reg(4'h2, 8'(m % 4));
                repeat (2) @(negedge clk_i);
                check("frontend cfg", cfg, cfg_exp(m % 4, i % 8, i, bias));
            end
        end
        ofs = 24'($urandom);
        for (int k = 0; k < 3; k++)
            host.write_reg(4'(4 + k), ofs[8*k +: 8]);
        check_ofs();
        fullscale_coeff = 24'($urandom);
        run_samples(20);
        fork
            host.write_reg(4'h4, 8'h5a);
            begin
                @(negedge clk_i);
                cal_done = 1'b1;
                cal_val = 24'($urandom);
                @(negedge clk_i);
                cal_done = 1'b0;
            end
        join
        ofs = cal_val;
        check_ofs();
        fullscale_coeff = 24'hffffff;
        run_samples(20);
        tally_and_finish();
    end
endmodule // adc_monitor_gain_offset_regs_test
